// ==== rtl/dioz_top.sv ====
// Purpose: digital i/o terminal logic with polarity, drive mode and freeze
// Assumes: terminal inputs are asynchronous, freeze_ext is on clk
// Notes:   registers over apb, answer two cycles into the access phase
`timescale 1ns/1ps
module dioz_top
	import dioz_pkg::*;
(
	input  wire logic          clk,            // 250 MHz clock
	input  wire logic          resetn,         // synchronous reset, active low
	input  wire dioz_apb_req_t apb_req,        // apb request signals
	output logic               pready,         // apb ready
	output logic [31:0]        prdata,         // apb read data
	output logic               pslverr,        // apb error, unmapped address
	input  wire logic [5:0]    term_in,        // levels of terminals 1..6
	output logic [2:0]         term_out,       // bidir terminal drive level
	output logic [2:0]         term_oe,        // bidir terminal driver on
	output logic               relay_close,    // relay contact closed
	output logic               supply_on,      // 24v supply output on
	output logic               ref2_select,    // routed analog ref 2 select
	output logic               jog_cmd,        // routed jog command
	output logic [1:0]         preset_select,  // routed preset select bits
	input  wire logic          freeze_ext,     // freeze from attached modules
	output logic               freeze_line     // common freeze line pulse
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	dioz_cfg_t   cfg_q, cfg_d;
	logic [5:0]  inv_q, inv_d;
	logic [2:0]  dest4_q, dest4_d;
	logic [2:0]  dest5_q, dest5_d;
	logic [2:0]  dest6_q, dest6_d;
	logic [2:0]  mode_q, mode_d;
	logic [4:0]  outv_q, outv_d;
	logic        flag_q, flag_d;
	logic [5:0]  s1_q, s2_q, s3_q, st_q;
	logic [5:0]  st_d;
	logic        prev4_q, prev4_d;
	logic        line_q, line_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic [2:0]  tout_q, tout_d;
	logic [2:0]  toe_q, toe_d;
	logic        relay_q, relay_d;
	logic        supply_q, supply_d;
	logic        ref2_q, ref2_d;
	logic        jog_q, jog_d;
	logic [1:0]  pre_q, pre_d;

	logic [5:0]  logic_in;
	logic        freeze_en;
	logic        freeze_evt;
	logic        wr_take;
	logic        rd_start;
	logic        hit;
	logic [31:0] rd_val;

	// ------------------------------------------------------------
	// input conditioning
	// ------------------------------------------------------------
	// a change counts only when the second and third stages agree
	always_comb
	begin
		st_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & st_q);
	end

	always_comb
	begin
		logic_in = st_q ^ {6{~cfg_q.pol}} ^ inv_q;
	end

	// ------------------------------------------------------------
	// freeze
	// ------------------------------------------------------------
	always_comb
	begin
		freeze_en = (dest4_q == DIOZ_DEST_FREEZE);
		// in positive polarity, inverting input 4 turns its falling terminal edge into a rising logic edge
		freeze_evt = freeze_en & logic_in[DIOZ_IN4] & ~prev4_q;
		prev4_d = logic_in[DIOZ_IN4];
		line_d = freeze_evt;
	end

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	always_comb
	begin
		rd_start = apb_req.psel & apb_req.penable & ~pready_q;
		wr_take = apb_req.psel & apb_req.penable & pready_q & apb_req.pwrite;
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		if (apb_req.paddr == DIOZ_OFS_CFG)
		begin
			rd_val[5:0] = cfg_q;
		end
		else if (apb_req.paddr == DIOZ_OFS_INVERT)
		begin
			rd_val[5:0] = inv_q;
		end
		else if (apb_req.paddr == DIOZ_OFS_IN4_DEST)
		begin
			rd_val[2:0] = dest4_q;
		end
		else if (apb_req.paddr == DIOZ_OFS_IN5_DEST)
		begin
			rd_val[2:0] = dest5_q;
		end
		else if (apb_req.paddr == DIOZ_OFS_IN6_DEST)
		begin
			rd_val[2:0] = dest6_q;
		end
		else if (apb_req.paddr == DIOZ_OFS_REF_MODE)
		begin
			rd_val[2:0] = mode_q;
		end
		else if (apb_req.paddr == DIOZ_OFS_FREEZE)
		begin
			rd_val[0] = flag_q;
		end
		else if (apb_req.paddr == DIOZ_OFS_OUT_VAL)
		begin
			rd_val[4:0] = outv_q;
		end
		else if (apb_req.paddr == DIOZ_OFS_IN_STATE)
		begin
			rd_val[5:0] = logic_in;
		end
		else
		begin
			hit = 1'b0;
		end
		pready_d = rd_start;
		pslverr_d = rd_start & ~hit;
		prdata_d = (rd_start & ~apb_req.pwrite) ? rd_val : 32'h0000_0000;
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	always_comb
	begin
		cfg_d = cfg_q;
		inv_d = inv_q;
		dest4_d = dest4_q;
		dest5_d = dest5_q;
		dest6_d = dest6_q;
		mode_d = mode_q;
		outv_d = outv_q;
		flag_d = flag_q;
		if (wr_take)
		begin
			if (apb_req.paddr == DIOZ_OFS_CFG)
			begin
				cfg_d = apb_req.pwdata[5:0];
			end
			else if (apb_req.paddr == DIOZ_OFS_INVERT)
			begin
				inv_d = apb_req.pwdata[5:0];
			end
			else if (apb_req.paddr == DIOZ_OFS_IN4_DEST)
			begin
				dest4_d = apb_req.pwdata[2:0];
			end
			else if (apb_req.paddr == DIOZ_OFS_IN5_DEST)
			begin
				dest5_d = apb_req.pwdata[2:0];
			end
			else if (apb_req.paddr == DIOZ_OFS_IN6_DEST)
			begin
				dest6_d = apb_req.pwdata[2:0];
			end
			else if (apb_req.paddr == DIOZ_OFS_REF_MODE)
			begin
				mode_d = apb_req.pwdata[2:0];
			end
			else if (apb_req.paddr == DIOZ_OFS_FREEZE)
			begin
				flag_d = apb_req.pwdata[0];
			end
			else if (apb_req.paddr == DIOZ_OFS_OUT_VAL)
			begin
				outv_d = apb_req.pwdata[4:0];
			end
		end
		// a freeze event in the clearing cycle still sets the flag
		if (freeze_en & (freeze_evt | freeze_ext))
		begin
			flag_d = 1'b1;
		end
		// routing follows modes 0 to 5 while enabled, modes 6 and 7 keep it; software writes are overridden
		if (~cfg_q.auto_dis)
		begin
			case (mode_q)
				3'h0, 3'h4, 3'h5:
				begin
					dest5_d = DIOZ_DEST_REF2;
					dest6_d = DIOZ_DEST_JOG;
				end
				3'h1, 3'h2, 3'h3:
				begin
					dest5_d = DIOZ_DEST_PRE0;
					dest6_d = DIOZ_DEST_PRE1;
				end
				default:
				begin
					dest5_d = dest5_q;
					dest6_d = dest6_q;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// terminal outputs and routing
	// ------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			// output value 1 drives high in positive, low in negative polarity
			tout_d[i] = outv_q[i] ~^ cfg_q.pol;
			if (cfg_q.oc)
			begin
				// only the driver that pulls toward the active rail stays on
				toe_d[i] = cfg_q.dir[i] & (cfg_q.pol ? tout_d[i] : ~tout_d[i]);
			end
			else
			begin
				toe_d[i] = cfg_q.dir[i];
			end
		end
		relay_d = outv_q[DIOZ_OUT_RELAY];
		supply_d = outv_q[DIOZ_OUT_SUPPLY];
		ref2_d = 1'b0;
		jog_d = 1'b0;
		pre_d = 2'h0;
		// only inputs 4 to 6 are routed; the bidirectional terminals give no input routing
		if (dest4_q == DIOZ_DEST_REF2) ref2_d = ref2_d | logic_in[DIOZ_IN4];
		if (dest5_q == DIOZ_DEST_REF2) ref2_d = ref2_d | logic_in[DIOZ_IN5];
		if (dest6_q == DIOZ_DEST_REF2) ref2_d = ref2_d | logic_in[DIOZ_IN6];
		if (dest4_q == DIOZ_DEST_JOG) jog_d = jog_d | logic_in[DIOZ_IN4];
		if (dest5_q == DIOZ_DEST_JOG) jog_d = jog_d | logic_in[DIOZ_IN5];
		if (dest6_q == DIOZ_DEST_JOG) jog_d = jog_d | logic_in[DIOZ_IN6];
		if (dest4_q == DIOZ_DEST_PRE0) pre_d[0] = pre_d[0] | logic_in[DIOZ_IN4];
		if (dest5_q == DIOZ_DEST_PRE0) pre_d[0] = pre_d[0] | logic_in[DIOZ_IN5];
		if (dest6_q == DIOZ_DEST_PRE0) pre_d[0] = pre_d[0] | logic_in[DIOZ_IN6];
		if (dest4_q == DIOZ_DEST_PRE1) pre_d[1] = pre_d[1] | logic_in[DIOZ_IN4];
		if (dest5_q == DIOZ_DEST_PRE1) pre_d[1] = pre_d[1] | logic_in[DIOZ_IN5];
		if (dest6_q == DIOZ_DEST_PRE1) pre_d[1] = pre_d[1] | logic_in[DIOZ_IN6];
	end

	// ------------------------------------------------------------
	// flops
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			cfg_q <= '{pol: DIOZ_RST_POL, oc: DIOZ_RST_OC, dir: DIOZ_RST_DIR,
				auto_dis: DIOZ_RST_AUTO};
			inv_q <= DIOZ_RST_INV;
			dest4_q <= DIOZ_DEST_NONE;
			dest5_q <= DIOZ_DEST_REF2;
			dest6_q <= DIOZ_DEST_JOG;
			mode_q <= DIOZ_RST_MODE;
			outv_q <= DIOZ_RST_OUT;
			flag_q <= 1'b0;
			s1_q <= 6'h00;
			s2_q <= 6'h00;
			s3_q <= 6'h00;
			st_q <= 6'h00;
			prev4_q <= 1'b0;
			line_q <= 1'b0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			tout_q <= 3'h0;
			toe_q <= 3'h0;
			relay_q <= 1'b0;
			supply_q <= 1'b0;
			ref2_q <= 1'b0;
			jog_q <= 1'b0;
			pre_q <= 2'h0;
		end
		else
		begin
			cfg_q <= cfg_d;
			inv_q <= inv_d;
			dest4_q <= dest4_d;
			dest5_q <= dest5_d;
			dest6_q <= dest6_d;
			mode_q <= mode_d;
			outv_q <= outv_d;
			flag_q <= flag_d;
			s1_q <= term_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			st_q <= st_d;
			prev4_q <= prev4_d;
			line_q <= line_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
			tout_q <= tout_d;
			toe_q <= toe_d;
			relay_q <= relay_d;
			supply_q <= supply_d;
			ref2_q <= ref2_d;
			jog_q <= jog_d;
			pre_q <= pre_d;
		end
	end

	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign term_out = tout_q;
	assign term_oe = toe_q;
	assign relay_close = relay_q;
	assign supply_on = supply_q;
	assign ref2_select = ref2_q;
	assign jog_cmd = jog_q;
	assign preset_select = pre_q;
	assign freeze_line = line_q;

endmodule : dioz_top

// ==== rtl/dioz_pkg.sv ====
// Purpose: constants and types for the drive digital i/o and freeze block
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes:   offsets and field positions are local to this block
package dioz_pkg;

	localparam logic [7:0] DIOZ_OFS_CFG      = 8'h00;
	localparam logic [7:0] DIOZ_OFS_INVERT   = 8'h04;
	localparam logic [7:0] DIOZ_OFS_IN4_DEST = 8'h08;
	localparam logic [7:0] DIOZ_OFS_IN5_DEST = 8'h0C;
	localparam logic [7:0] DIOZ_OFS_IN6_DEST = 8'h10;
	localparam logic [7:0] DIOZ_OFS_REF_MODE = 8'h14;
	localparam logic [7:0] DIOZ_OFS_FREEZE   = 8'h18;
	localparam logic [7:0] DIOZ_OFS_OUT_VAL  = 8'h1C;
	localparam logic [7:0] DIOZ_OFS_IN_STATE = 8'h20;

	// cfg word fields
	localparam int DIOZ_CFG_POL  = 0;
	localparam int DIOZ_CFG_OC   = 1;
	localparam int DIOZ_CFG_DIR  = 2;
	localparam int DIOZ_CFG_AUTO = 5;

	// out value word fields: bits 2..0 bidirectional terminals
	localparam int DIOZ_OUT_RELAY  = 3;
	localparam int DIOZ_OUT_SUPPLY = 4;

	localparam int DIOZ_IN4 = 3;
	localparam int DIOZ_IN5 = 4;
	localparam int DIOZ_IN6 = 5;

	localparam logic       DIOZ_RST_POL  = 1'b1;
	localparam logic       DIOZ_RST_OC   = 1'b0;
	localparam logic [2:0] DIOZ_RST_DIR  = 3'h1;
	localparam logic       DIOZ_RST_AUTO = 1'b0;
	localparam logic [5:0] DIOZ_RST_INV  = 6'h00;
	localparam logic [2:0] DIOZ_RST_MODE = 3'h0;
	localparam logic [4:0] DIOZ_RST_OUT  = 5'h00;

	// destination codes
	localparam logic [2:0] DIOZ_DEST_NONE   = 3'h0;
	localparam logic [2:0] DIOZ_DEST_REF2   = 3'h1;
	localparam logic [2:0] DIOZ_DEST_JOG    = 3'h2;
	localparam logic [2:0] DIOZ_DEST_PRE0   = 3'h3;
	localparam logic [2:0] DIOZ_DEST_PRE1   = 3'h4;
	localparam logic [2:0] DIOZ_DEST_FREEZE = 3'h5;

	// packed from the top bit down, so pol lands on bit 0 and auto_dis on bit 5
	typedef struct packed {
		logic       auto_dis;
		logic [2:0] dir;
		logic       oc;
		logic       pol;
	} dioz_cfg_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dioz_apb_req_t;

endpackage : dioz_pkg

// ==== bench/dioz_top_asserts.sv ====
// Purpose: port-level checks for dioz_top
// Assumes: cfg and out words tracked from apb writes
// Notes:   one clock domain
`timescale 1ns/1ps
module dioz_top_asserts
	import dioz_pkg::*;
(
	input wire logic          clk,           // clock
	input wire logic          resetn,        // reset, active low
	input wire dioz_apb_req_t apb_req,       // apb request
	input wire logic          pready,        // apb ready
	input wire logic [31:0]   prdata,        // apb read data
	input wire logic          pslverr,       // apb error
	input wire logic [2:0]    term_out,      // bidir level
	input wire logic [2:0]    term_oe,       // bidir enable
	input wire logic          relay_close,   // relay closed
	input wire logic          supply_on,     // supply on
	input wire logic          freeze_line    // freeze pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic       wr_ok;
	logic [5:0] cfg_d, cfg_q;
	logic [4:0] out_d, out_q;
	assign wr_ok = pready & apb_req.psel & apb_req.penable & apb_req.pwrite & ~pslverr;
	always_comb
	begin
		cfg_d = cfg_q;
		out_d = out_q;
		if (wr_ok && apb_req.paddr == DIOZ_OFS_CFG)
			cfg_d = apb_req.pwdata[5:0];
		if (wr_ok && apb_req.paddr == DIOZ_OFS_OUT_VAL)
			out_d = apb_req.pwdata[4:0];
	end
	always_ff @(posedge clk)
	begin
		cfg_q <= resetn ? cfg_d : {DIOZ_RST_AUTO, DIOZ_RST_DIR, DIOZ_RST_OC, DIOZ_RST_POL};
		out_q <= resetn ? out_d : DIOZ_RST_OUT;
	end
	a_ready_timing: assert property ($rose(apb_req.penable) && apb_req.psel |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_prdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
	a_slverr_map: assert property (pready && apb_req.paddr[1:0] == 2'h0
		|-> pslverr == (apb_req.paddr > 8'h20)) else $error("pslverr wrong");
	a_dir_gates_oe: assert property ((term_oe & ~$past(cfg_q[4:2])) == 3'h0)
		else $error("input terminal driven");
	a_push_pull: assert property ($past(resetn) && !$past(cfg_q[1])
		|-> term_oe == $past(cfg_q[4:2])) else $error("push-pull enable wrong");
	a_open_coll: assert property ($past(resetn) && $past(cfg_q[1]) |-> term_oe ==
		($past(cfg_q[4:2]) & ($past(cfg_q[0]) ? term_out : ~term_out)))
		else $error("open collector enable wrong");
	a_relay_supply: assert property ($past(resetn)
		|-> {supply_on, relay_close} == $past(out_q[4:3])) else $error("relay or supply wrong");
	a_freeze_single: assert property (freeze_line |=> !freeze_line [*3])
		else $error("freeze pulse repeated");
	c_write: cover property (wr_ok);
	c_freeze: cover property (freeze_line);
	c_error: cover property (pready && pslverr);
endmodule : dioz_top_asserts
bind dioz_top dioz_top_asserts u_chk (.clk(clk), .resetn(resetn), .apb_req(apb_req),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .term_out(term_out),
	.term_oe(term_oe), .relay_close(relay_close), .supply_on(supply_on),
	.freeze_line(freeze_line));

// ==== bench/dioz_field.sv ====
// Purpose: field wiring at the terminals
// Assumes: an undriven bidir terminal takes the field level
// Notes:   released open-collector lines follow the field pull
`timescale 1ns/1ps
module dioz_field
(
	input  wire logic [2:0] term_out,  // drive level
	input  wire logic [2:0] term_oe,   // drive enable
	input  wire logic [5:0] drv,       // field levels
	output logic      [5:0] term_in    // terminal levels
);
	assign term_in = {drv[5:3], (term_oe & term_out) | (~term_oe & drv[2:0])};
endmodule : dioz_field

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench for dioz_top
// Assumes: apb answer awaited, no fixed latency
// Notes:   waits after terminal edges exceed the 5-cycle path
`timescale 1ns/1ps
module tb_top
	import dioz_pkg::*;
;
	logic          clk, resetn, pready, pslverr, relay_close, supply_on;
	logic          ref2_select, jog_cmd, freeze_ext, freeze_line;
	logic [1:0]    preset_select;
	logic [2:0]    term_out, term_oe;
	logic [5:0]    term_in, drv;
	logic [31:0]   prdata, rdat;
	logic          rerr;
	dioz_apb_req_t req;
	int            n_errors, cmp_count, n_frz, cycles;
	logic [31:0]   rv [8] = '{32'h5, 32'h0, 32'h0, 32'h1, 32'h2, 32'h0, 32'h0, 32'h0};
	dioz_top dut (.clk(clk), .resetn(resetn), .apb_req(req), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .term_in(term_in), .term_out(term_out),
		.term_oe(term_oe), .relay_close(relay_close), .supply_on(supply_on),
		.ref2_select(ref2_select), .jog_cmd(jog_cmd), .preset_select(preset_select),
		.freeze_ext(freeze_ext), .freeze_line(freeze_line));
	dioz_field u_field (.term_out(term_out), .term_oe(term_oe), .drv(drv), .term_in(term_in));
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (freeze_line === 1'b1)
			n_frz++;
		if (cycles == 20000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	task wrap_up();
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("FAIL %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("reg", rdat & m, e);
	endtask : rd
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task lvl(input logic [5:0] v);
		@(posedge clk);
		drv <= v;
		cyc(10);
	endtask : lvl
	task pulse_ext();
		@(posedge clk);
		freeze_ext <= 1'b1;
		@(posedge clk);
		freeze_ext <= 1'b0;
		cyc(3);
	endtask : pulse_ext
	initial
	begin
		clk = 0; resetn = 0; req = '0; drv = 6'h00; freeze_ext = 0;
		n_errors = 0; cmp_count = 0; n_frz = 0; cycles = 0;
		cyc(16);
		resetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(8'(i * 4), 32'hFFFFFFFF, rv[i]);
		chk("oe", 32'(term_oe), 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk("err", 32'(rerr), 32'h1);
		// -------------------------------------------------------
		// polarity, invert and outputs
		// -------------------------------------------------------
		lvl(6'h28);
		rd(DIOZ_OFS_IN_STATE, 32'h38, 32'h28);
		apb(1'b1, DIOZ_OFS_CFG, 32'h04);
		rd(DIOZ_OFS_IN_STATE, 32'h38, 32'h10);
		apb(1'b1, DIOZ_OFS_INVERT, 32'h08);
		rd(DIOZ_OFS_IN_STATE, 32'h38, 32'h18);
		apb(1'b1, DIOZ_OFS_INVERT, 32'h00);
		apb(1'b1, DIOZ_OFS_CFG, 32'h05);
		apb(1'b1, DIOZ_OFS_OUT_VAL, 32'h19);
		cyc(3);
		chk("out", 32'(term_out[0]), 32'h1);
		apb(1'b1, DIOZ_OFS_CFG, 32'h04);
		cyc(3);
		chk("out", 32'(term_out[0]), 32'h0);
		chk("rly", 32'({supply_on, relay_close}), 32'h3);
		apb(1'b1, DIOZ_OFS_CFG, 32'h06);
		cyc(3);
		chk("oe", 32'(term_oe), 32'h1);
		apb(1'b1, DIOZ_OFS_CFG, 32'h07);
		cyc(3);
		chk("oe", 32'(term_oe), 32'h1);
		apb(1'b1, DIOZ_OFS_OUT_VAL, 32'h18);
		cyc(3);
		chk("oe", 32'(term_oe), 32'h0);
		apb(1'b1, DIOZ_OFS_CFG, 32'h19);
		cyc(3);
		chk("oe", 32'(term_oe), 32'h6);
		apb(1'b1, DIOZ_OFS_CFG, 32'h05);
		// -------------------------------------------------------
		// automatic routing of inputs 5 and 6
		// -------------------------------------------------------
		lvl(6'h30);
		for (int m = 0; m < 8; m++)
		begin
			apb(1'b1, DIOZ_OFS_REF_MODE, 32'(m));
			cyc(2);
			rd(DIOZ_OFS_IN5_DEST, 32'h7, (m inside {[1:3]}) ? 32'h3 : 32'h1);
			rd(DIOZ_OFS_IN6_DEST, 32'h7, (m inside {[1:3]}) ? 32'h4 : 32'h2);
			cyc(6);
			chk("rt", 32'({ref2_select, jog_cmd, preset_select}),
				(m inside {[1:3]}) ? 32'h3 : 32'hC);
		end
		apb(1'b1, DIOZ_OFS_CFG, 32'h25);
		apb(1'b1, DIOZ_OFS_IN5_DEST, 32'h0);
		apb(1'b1, DIOZ_OFS_REF_MODE, 32'h1);
		cyc(3);
		rd(DIOZ_OFS_IN5_DEST, 32'h7, 32'h0);
		apb(1'b1, DIOZ_OFS_CFG, 32'h05);
		// -------------------------------------------------------
		// freeze on input 4
		// -------------------------------------------------------
		lvl(6'h00);
		apb(1'b1, DIOZ_OFS_IN4_DEST, 32'h5);
		n_frz = 0;
		lvl(6'h08);
		chk("frz", 32'(n_frz), 32'h1);
		rd(DIOZ_OFS_FREEZE, 32'h1, 32'h1);
		lvl(6'h00);
		lvl(6'h08);
		chk("frz", 32'(n_frz), 32'h2);
		apb(1'b1, DIOZ_OFS_FREEZE, 32'h0);
		rd(DIOZ_OFS_FREEZE, 32'h1, 32'h0);
		apb(1'b1, DIOZ_OFS_INVERT, 32'h08);
		lvl(6'h00);
		chk("frz", 32'(n_frz), 32'h3);
		apb(1'b1, DIOZ_OFS_FREEZE, 32'h0);
		pulse_ext();
		rd(DIOZ_OFS_FREEZE, 32'h1, 32'h1);
		apb(1'b1, DIOZ_OFS_IN4_DEST, 32'h0);
		apb(1'b1, DIOZ_OFS_FREEZE, 32'h0);
		pulse_ext();
		lvl(6'h08);
		rd(DIOZ_OFS_FREEZE, 32'h1, 32'h0);
		chk("frz", 32'(n_frz), 32'h3);
		wrap_up();
	end
endmodule : tb_top
